// >>> testbench/omc_host_model.sv
// Host processor model: power-on pin and command pulses.
// Assumes the controller samples on the rising sys_clk_i edge.
`timescale 1ns/100ps
module omc_host_model (
   input wire logic sys_clk_i,
   output logic power_on_input_o,
   output omc_pkg::omc_host_t host_o
);
   // Idle: pin released low, no command
   initial begin
      power_on_input_o = 1'h0;
      host_o = '0;
   end
   task automatic press();
      @(posedge sys_clk_i) power_on_input_o <= 1'h1;
      repeat (6) @(posedge sys_clk_i);
      power_on_input_o <= 1'h0;
      // Low long enough that a following press is a fresh edge
      repeat (6) @(posedge sys_clk_i);
   endtask
   task automatic cmd(input logic [3:0] v);
      @(posedge sys_clk_i) host_o <= omc_pkg::omc_host_t'(v);
      @(posedge sys_clk_i) host_o <= '0;
   endtask
endmodule

// >>> testbench/operating_mode_controller_tb_top.sv
// Self-checking bench of the operating mode controller.
// Assumes the host model drives the pin and host command pulses.
`timescale 1ns/100ps
module operating_mode_controller_tb_top;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic sys_clk_i = 1'h0;
   logic resetn_i = 1'h0;
   logic supply_good_i = 1'h0; // Supply absent at start
   logic power_on_input_i;
   omc_pkg::omc_host_t host_i;
   omc_pkg::omc_radio_t radio_i = '0;
   omc_pkg::omc_mode_t mode_o;
   omc_pkg::omc_en_t en_o;
   logic ps_enabled_o;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0; // Hang guard
   always #25 sys_clk_i = ~sys_clk_i;
   omc_host_model host (
      .sys_clk_i(sys_clk_i),
      .power_on_input_o(power_on_input_i),
      .host_o(host_i)
   );
   omc_mode_ctrl dut (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .supply_good_i(supply_good_i),
      .power_on_input_i(power_on_input_i),
      .host_i(host_i),
      .radio_i(radio_i),
      .mode_o(mode_o),
      .en_o(en_o),
      .ps_enabled_o(ps_enabled_o)
   );
   // ---------------------------------------------------------------
   // Compare and drive helpers
   // ---------------------------------------------------------------
   task automatic chk_mode(input omc_pkg::omc_mode_t exp);
      n_compared++;
      if (mode_o !== exp) begin
         errors++;
         $display("unexpected mode_o exp %0h got %0h", exp, mode_o);
      end
   endtask
   // Masked, since some enables are left open in some modes
   task automatic chk_en(input logic [3:0] m, input logic [3:0] exp);
      n_compared++;
      if ((en_o & m) !== exp) begin
         errors++;
         $display("unexpected en_o exp %0h got %0h", exp, en_o & m);
      end
   endtask
   task automatic chk_ps(input logic exp);
      n_compared++;
      if (ps_enabled_o !== exp) begin
         errors++;
         $display("unexpected ps_enabled_o exp %0h got %0h", exp,
            ps_enabled_o);
      end
   endtask
   // Pins go through a synchroniser, so the wait is bounded
   task automatic wait_mode(input omc_pkg::omc_mode_t exp);
      for (int i = 0; i < 12 && mode_o !== exp; i++) @(posedge sys_clk_i);
      #1;
      chk_mode(exp);
   endtask
   task automatic supply(input logic v, input omc_pkg::omc_mode_t exp);
      @(posedge sys_clk_i) supply_good_i <= v;
      wait_mode(exp);
   endtask
   task automatic prs(input omc_pkg::omc_mode_t exp);
      host.press();
      wait_mode(exp);
   endtask
   // Pulses answer on the same edge that samples them, checked 1 ns later
   task automatic hcmd(input logic [3:0] v, input omc_pkg::omc_mode_t exp);
      host.cmd(v);
      #1;
      chk_mode(exp);
   endtask
   task automatic rad(input logic [3:0] v, input omc_pkg::omc_mode_t exp);
      @(posedge sys_clk_i) radio_i <= omc_pkg::omc_radio_t'(v);
      @(posedge sys_clk_i) radio_i <= '0;
      #1;
      chk_mode(exp);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_boot();
      supply(1'h1, omc_pkg::OMC_OFF);
      chk_ps(1'h0);
      chk_en(4'h8, 4'h0);
      hcmd(4'h4, omc_pkg::OMC_OFF);
      rad(4'h8, omc_pkg::OMC_OFF);
      prs(omc_pkg::OMC_ACT);
      chk_en(4'hE, 4'hE);
   endtask
   task automatic t_conn();
      rad(4'h2, omc_pkg::OMC_ACT);
      rad(4'h1, omc_pkg::OMC_ACT);
      rad(4'h8, omc_pkg::OMC_CONN);
      chk_en(4'h6, 4'h6);
      rad(4'h2, omc_pkg::OMC_CONN);
      rad(4'h4, omc_pkg::OMC_ACT);
   endtask
   task automatic t_sleep();
      hcmd(4'h3, omc_pkg::OMC_ACT);
      chk_ps(1'h1);
      chk_en(4'hE, 4'h6);
      rad(4'h2, omc_pkg::OMC_SLEEP);
      chk_en(4'hF, 4'h1);
      rad(4'h4, omc_pkg::OMC_SLEEP);
      rad(4'h1, omc_pkg::OMC_ACT);
      rad(4'h2, omc_pkg::OMC_SLEEP);
      hcmd(4'h8, omc_pkg::OMC_ACT);
      rad(4'h2, omc_pkg::OMC_SLEEP);
      prs(omc_pkg::OMC_ACT);
      rad(4'h2, omc_pkg::OMC_SLEEP);
      rad(4'h8, omc_pkg::OMC_ACT);
      @(posedge sys_clk_i);
      #1;
      chk_mode(omc_pkg::OMC_CONN);
      rad(4'h4, omc_pkg::OMC_ACT);
      rad(4'h2, omc_pkg::OMC_SLEEP);
      hcmd(4'h2, omc_pkg::OMC_SLEEP);
      chk_ps(1'h0);
      prs(omc_pkg::OMC_ACT);
   endtask
   task automatic t_off();
      hcmd(4'h4, omc_pkg::OMC_OFF);
      chk_en(4'h8, 4'h0);
      prs(omc_pkg::OMC_ACT);
      prs(omc_pkg::OMC_OFF);
      supply(1'h0, omc_pkg::OMC_NOPWR);
      supply(1'h1, omc_pkg::OMC_OFF);
      prs(omc_pkg::OMC_ACT);
      rad(4'h8, omc_pkg::OMC_CONN);
      supply(1'h0, omc_pkg::OMC_NOPWR);
      chk_en(4'hF, 4'h0);
   endtask
   // ---------------------------------------------------------------
   // Verdict, hang guard and main sequence
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Whole run needs under two hundred cycles
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk_i);
      resetn_i <= 1'h1;
      t_boot();
      t_conn();
      t_sleep();
      t_off();
      final_report();
   end
endmodule

// >>> verilog/omc_mode_ctrl.sv
// Operating mode state machine of the modem power sequencer.
// Assumes host commands and radio events arrive as one-cycle pulses on
// sys_clk_i; power-on pin and supply-good come from pins.
`timescale 1ns/100ps
module omc_mode_ctrl (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic supply_good_i,          // Main supply pin, high = ok
   input wire logic power_on_input_i,       // Power-on pin, high = press
   input wire omc_pkg::omc_host_t host_i,   // Host command pulses
   input wire omc_pkg::omc_radio_t radio_i, // Radio and timer pulses
   output omc_pkg::omc_mode_t mode_o,       // Present operating mode
   output omc_pkg::omc_en_t en_o,           // Clock and domain enables
   output logic ps_enabled_o                // Power saving configured
);
   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic supply_lvl;    // Clean supply level
   logic pwr_rise;      // Power-on press, one cycle

   omc_pin_sync u_supply_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i(supply_good_i),
      .level_o(supply_lvl),
      .rise_o()
   );

   omc_pin_sync u_pwr_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i(power_on_input_i),
      .level_o(),
      .rise_o(pwr_rise)
   );

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   omc_pkg::omc_mode_t mode_q;   // Present mode
   omc_pkg::omc_mode_t mode_d;
   logic ps_q;                   // Power saving configuration
   logic ps_d;
   logic pend_conn_q;            // Radio need pending across wake-up
   logic pend_conn_d;
   omc_pkg::omc_en_t en_q;       // Registered enables
   omc_pkg::omc_en_t en_d;
   logic power_on;               // Pin press or host-side pulse

   assign power_on = pwr_rise | host_i.power_on;

   // Next mode, flags and enables
   always_comb begin
      mode_d = mode_q;
      ps_d = ps_q;
      pend_conn_d = pend_conn_q;
      if (host_i.ps_cfg) begin
         ps_d = host_i.ps_cfg_en;
      end
      if (!supply_lvl) begin
         mode_d = omc_pkg::OMC_NOPWR;
         pend_conn_d = 1'b0;
      end else begin
         unique case (mode_q)
            omc_pkg::OMC_NOPWR: begin
               mode_d = omc_pkg::OMC_OFF;
            end
            omc_pkg::OMC_OFF: begin
               if (power_on) begin
                  mode_d = omc_pkg::OMC_ACT;
               end
            end
            omc_pkg::OMC_ACT: begin
               // switch-off first, it outranks radio events
               if (host_i.switch_off || power_on) begin
                  mode_d = omc_pkg::OMC_OFF;
                  pend_conn_d = 1'b0;
               end else if (radio_i.conn_start || pend_conn_q) begin
                  mode_d = omc_pkg::OMC_CONN;
                  pend_conn_d = 1'b0;
               end else if (ps_q && radio_i.active_tmo) begin
                  mode_d = omc_pkg::OMC_SLEEP;
               end
            end
            omc_pkg::OMC_CONN: begin
               if (radio_i.conn_end) begin
                  mode_d = omc_pkg::OMC_ACT;
               end
            end
            omc_pkg::OMC_SLEEP: begin
               if (radio_i.conn_start) begin
                  mode_d = omc_pkg::OMC_ACT;
                  pend_conn_d = 1'b1;
               end else if (radio_i.periodic_tmo || power_on) begin
                  mode_d = omc_pkg::OMC_ACT;
               end
            end
            default: begin
               mode_d = omc_pkg::OMC_NOPWR;
            end
         endcase
      end
      // other events fall through unchanged above
      en_d.fast_ref_en = (mode_d == omc_pkg::OMC_ACT) ||
                         (mode_d == omc_pkg::OMC_CONN);
      en_d.slow_ref_en = (mode_d != omc_pkg::OMC_NOPWR) &&
                         (mode_d != omc_pkg::OMC_OFF);
      en_d.radio_en = (mode_d == omc_pkg::OMC_CONN) ||
                      (mode_d == omc_pkg::OMC_ACT);
      // Interfaces closed in active when power saving is configured
      en_d.app_if_en = ((mode_d == omc_pkg::OMC_ACT) && !ps_d) ||
                       (mode_d == omc_pkg::OMC_CONN);
   end

   // Registers only
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_q <= omc_pkg::OMC_NOPWR;
         ps_q <= omc_pkg::OMC_PS_RESET;
         pend_conn_q <= 1'b0;
         en_q <= '0;
      end else begin
         mode_q <= mode_d;
         ps_q <= ps_d;
         pend_conn_q <= pend_conn_d;
         en_q <= en_d;
      end
   end

   assign mode_o = mode_q;
   assign en_o = en_q;
   assign ps_enabled_o = ps_q;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_wake_by_radio;
      mode_q == omc_pkg::OMC_SLEEP && supply_lvl && radio_i.conn_start;
   endsequence

   // Connection ended or suspended while powered
   sequence s_conn_drop;
      mode_q == omc_pkg::OMC_CONN && supply_lvl && radio_i.conn_end;
   endsequence

   supply_loss_a: assert property (
      !supply_lvl |=> mode_q == omc_pkg::OMC_NOPWR)
      else $error("mode not cleared on supply loss");
   supply_up_a: assert property (
      mode_q == omc_pkg::OMC_NOPWR && supply_lvl |=>
      mode_q == omc_pkg::OMC_OFF)
      else $error("no power-off after supply applied");
   switch_off_a: assert property (
      mode_q == omc_pkg::OMC_ACT && supply_lvl && host_i.switch_off |=>
      mode_q == omc_pkg::OMC_OFF)
      else $error("switch-off ignored");
   switch_on_a: assert property (
      mode_q == omc_pkg::OMC_OFF && supply_lvl && power_on |=>
      mode_q == omc_pkg::OMC_ACT)
      else $error("switch-on ignored");
   off_closed_a: assert property (
      mode_q == omc_pkg::OMC_OFF |-> !en_q.app_if_en && !en_q.radio_en)
      else $error("interfaces open while off");
   sleep_ref_a: assert property (
      mode_q == omc_pkg::OMC_SLEEP |->
      en_q.slow_ref_en && !en_q.fast_ref_en && !en_q.app_if_en)
      else $error("sleep enables wrong");
   sleep_gate_a: assert property (
      mode_q == omc_pkg::OMC_ACT ##1 mode_q == omc_pkg::OMC_SLEEP |->
      $past(ps_q))
      else $error("sleep entered with power saving off");
   radio_wake_a: assert property (
      s_wake_by_radio |=> mode_q == omc_pkg::OMC_ACT ##1
      (mode_q == omc_pkg::OMC_CONN || !supply_lvl ||
       $past(host_i.switch_off) || $past(power_on)))
      else $error("radio wake did not connect");
   fast_ref_a: assert property (
      mode_q == omc_pkg::OMC_CONN |-> en_q.fast_ref_en && en_q.radio_en)
      else $error("connected without fast reference");
   off_unpower_a: assert property (
      mode_q == omc_pkg::OMC_OFF && !supply_lvl |=>
      mode_q == omc_pkg::OMC_NOPWR)
      else $error("power-off kept after supply removal");
   ps_hold_a: assert property (
      !host_i.ps_cfg |=> ps_q == $past(ps_q))
      else $error("power saving changed without command");
   sleep_wake_a: assert property (
      mode_q == omc_pkg::OMC_SLEEP && supply_lvl &&
      (radio_i.periodic_tmo || power_on) |=> mode_q == omc_pkg::OMC_ACT)
      else $error("sleep did not wake");
   act_if_a: assert property (
      mode_q == omc_pkg::OMC_ACT |-> en_q.app_if_en == !ps_q)
      else $error("interfaces wrong in active mode");
   conn_enter_a: assert property (
      mode_q == omc_pkg::OMC_ACT && supply_lvl && radio_i.conn_start &&
      !host_i.switch_off && !power_on |=> mode_q == omc_pkg::OMC_CONN)
      else $error("connection start ignored");
   conn_leave_a: assert property (
      s_conn_drop |=> mode_q == omc_pkg::OMC_ACT)
      else $error("connection end ignored");
   // Only a connection end or supply loss may leave connected mode
   conn_hold_a: assert property (
      mode_q == omc_pkg::OMC_CONN && supply_lvl && !radio_i.conn_end |=>
      mode_q == omc_pkg::OMC_CONN)
      else $error("connected mode left without cause");
endmodule

// >>> verilog/omc_pin_sync.sv
// Three-stage synchroniser for the power-on and supply-good pins.
// Assumes the pin is asynchronous to sys_clk_i; emits a clean level
// and a one-cycle pulse on each rising change.
`timescale 1ns/100ps
module omc_pin_sync (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o
);
   // -----------------------------------------------------------------
   // Stages
   // -----------------------------------------------------------------
   logic [omc_pkg::OMC_SYNC_STAGES-1:0] sync_q; // Stage 0 is metastable
   logic [omc_pkg::OMC_SYNC_STAGES-1:0] sync_d;
   logic level_q;   // Accepted level
   logic level_d;

   // Next values: accept a change only when stages 1 and 2 agree
   always_comb begin
      sync_d = {sync_q[omc_pkg::OMC_SYNC_STAGES-2:0], pin_i};
      level_d = level_q;
      if (sync_q[omc_pkg::OMC_SYNC_STAGES-2] ==
          sync_q[omc_pkg::OMC_SYNC_STAGES-1]) begin
         level_d = sync_q[omc_pkg::OMC_SYNC_STAGES-1];
      end
   end

   // Registers only
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_q <= '0;
         level_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         level_q <= level_d;
      end
   end

   assign level_o = level_q;
   // Rising edge of the accepted level, stage 0 never looked at
   assign rise_o = level_d & ~level_q;
endmodule

// >>> verilog/omc_pkg.sv
// Shared types and constants of the operating mode controller.
// Assumes a single 20 MHz system clock; no software registers.
package omc_pkg;
   // -----------------------------------------------------------------
   // Operating modes
   // -----------------------------------------------------------------
   // Gray codes along not-powered, off, active, connected, sleep
   typedef enum logic [2:0] {
      OMC_NOPWR = 3'h0,
      OMC_OFF   = 3'h1,
      OMC_ACT   = 3'h3,
      OMC_CONN  = 3'h2,
      OMC_SLEEP = 3'h6
   } omc_mode_t;

   // -----------------------------------------------------------------
   // Request, event and enable carriers
   // -----------------------------------------------------------------
   // Host side, one-cycle pulses except the levels noted
   typedef struct packed {
      logic power_on;        // Power-on input edge, already cleaned
      logic switch_off;      // Switch-off command pulse
      logic ps_cfg;          // Power-saving configuration command pulse
      logic ps_cfg_en;       // Enable value carried by that command
   } omc_host_t;

   // Radio side and timer events, one-cycle pulses
   typedef struct packed {
      logic conn_start;      // Data connection initiated or needed
      logic conn_end;        // Connection terminated or suspended
      logic active_tmo;      // Active timer expired
      logic periodic_tmo;    // Periodic update timer expired
   } omc_radio_t;

   // Enables seen by the rest of the device
   typedef struct packed {
      logic app_if_en;       // Application interfaces reachable
      logic radio_en;        // Radio section powered
      logic fast_ref_en;     // 19.2 MHz core reference running
      logic slow_ref_en;     // 32 kHz reference running
   } omc_en_t;

   // -----------------------------------------------------------------
   // Pin synchroniser and power-saving reset value
   // -----------------------------------------------------------------
   localparam int OMC_SYNC_STAGES = 3;
   localparam logic OMC_PS_RESET = 1'b0; // Power saving off after reset
endpackage
